/* File: hdl/stcl_regs.vh */
// Constants of the temperature compensation and linearization datapath
// Operation
// - Invert control swaps positive and negative bridge inputs before the signal path.
// - Offset correction is applied ahead of the gain, so gain scales it.
// - First gap temperature difference is first knee minus filtered temperature.
// - Second gap difference is measured from the first knee, its lower end.
// - Third and fourth gaps measure difference from their lower boundary knee.
// - First-gap coefficients apply for temperatures from zero up to first knee.
// - Fourth gap runs from third knee to top code; no fourth knee exists.
// - Linearization runs only in digital mode; analog mode bypasses it.
// - One shared five-slot store holds temperature and linearization coefficients.
// - Slope code 1024 is unity and leaves the signal unchanged.
// - Coefficients are 12-bit sign, one integer bit, ten fraction bits.
// - Offset correction accumulates full corrections of every lower gap.
// - Gain code is coarse gain times fine gain plus coefficient times difference.
// - Linear output is break point plus slope times signal minus break point.
`ifndef STCL_REGS_VH
`define STCL_REGS_VH
`define STCL_TOP_CODE 10'h3ff
`define STCL_UNITY_COEF 12'h400
`define STCL_SIGN_BIT 11
`define STCL_FRAC_BITS 10
`define STCL_NUM_SLOTS 3'h5
`define STCL_MAX_TGAPS 3'h4
`define STCL_MIN_TGAPS 3'h1
`define STCL_OFS_MID 16'h0200
`define STCL_SLOT_RST 24'h000000
`define STCL_HI_MSB 23
`define STCL_HI_LSB 12
`define STCL_LO_MSB 11
`endif

/* File: hdl/stcl_fxmul.v */
// Sign-magnitude fixed-point coefficient times signed difference
`timescale 1ns/1ps
`include "stcl_regs.vh"
module stcl_fxmul (
  input wire [11:0] coef,
  input wire signed [10:0] val,
  output wire signed [12:0] prod
);
  // Magnitude with one integer and ten fraction bits
  wire signed [11:0] mag_s = {1'b0, coef[`STCL_SIGN_BIT-1:0]};
  wire signed [22:0] full = mag_s * val;
  // Drop the fraction; 2048 is minus zero and gives zero
  wire signed [12:0] scaled = full[22:`STCL_FRAC_BITS];
  assign prod = coef[`STCL_SIGN_BIT] ? -scaled : scaled;
endmodule

/* File: hdl/stcl_lin_core.v */
// Temperature compensation and signal linearization datapath
`timescale 1ns/1ps
`include "stcl_regs.vh"
module stcl_lin_core (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  input wire invert_sel,
  input wire digital_mode,
  input wire sig_valid,
  input wire [9:0] bridge_in_pos,
  input wire [9:0] bridge_in_neg,
  input wire temp_valid,
  input wire [9:0] temp_filt,
  input wire [9:0] temp_knee_first,
  input wire [9:0] temp_knee_second,
  input wire [9:0] temp_knee_third,
  input wire [2:0] coarse_gain_sel,
  input wire [9:0] fine_gain,
  input wire [1:0] coarse_offset_sel,
  input wire [9:0] fine_offset,
  input wire [2:0] num_temp_gaps,
  input wire coef_wr_en,
  input wire [2:0] coef_wr_idx,
  input wire [11:0] coef_wr_hi,
  input wire [11:0] coef_wr_lo,
  output reg [1:0] active_gap_q,
  output reg signed [15:0] dac_gain_q,
  output reg signed [15:0] dac_offset_q,
  output reg [9:0] sig_out_q,
  output reg [1:0] lin_gap_q,
  output reg out_valid_q
);
  // Clamp a wide signed value into the converter range
  function [9:0] sat10;
    input signed [22:0] v;
    begin
      if (v < 0)
        sat10 = 10'h000;
      else if (v > $signed({13'h0000, `STCL_TOP_CODE}))
        sat10 = `STCL_TOP_CODE;
      else
        sat10 = v[9:0];
    end
  endfunction

  reg [23:0] slot_q [0:4];
  reg signed [10:0] dt_q;
  reg signed [10:0] seg21_q;
  reg signed [10:0] seg32_q;
  reg [9:0] raw_q;
  reg raw_vld_q;
  reg [9:0] cond_q;
  reg cond_vld_q;
  reg [1:0] gap_d;
  reg signed [10:0] dt_d;
  reg [1:0] lgap_d;
  reg [2:0] probe_idx;
  integer k;
  integer i;

  // Temperature gap count kept inside one to four so slots stay shared
  wire [2:0] ntg = (num_temp_gaps < `STCL_MIN_TGAPS) ? `STCL_MIN_TGAPS :
                   (num_temp_gaps > `STCL_MAX_TGAPS) ? `STCL_MAX_TGAPS : num_temp_gaps;
  wire [2:0] nlg = `STCL_NUM_SLOTS - ntg;

  wire [10:0] t_ext = {1'b0, temp_filt};
  wire [10:0] k1_ext = {1'b0, temp_knee_first};
  wire [10:0] k2_ext = {1'b0, temp_knee_second};
  wire [10:0] k3_ext = {1'b0, temp_knee_third};

  // Gap choice; above the third knee the top code bounds the last gap
  always @*
  begin
    gap_d = 2'h0;
    dt_d = k1_ext - t_ext;
    if (temp_filt > temp_knee_third)
    begin
      gap_d = 2'h3;
      dt_d = t_ext - k3_ext;
    end
    else if (temp_filt > temp_knee_second)
    begin
      gap_d = 2'h2;
      dt_d = t_ext - k2_ext;
    end
    else if (temp_filt > temp_knee_first)
    begin
      gap_d = 2'h1;
      dt_d = t_ext - k1_ext;
    end
  end

  // Temperature gap coefficients live in slots zero up to ntg minus one
  wire [23:0] tslot = slot_q[{1'b0, active_gap_q}];
  wire signed [12:0] gain_adj;
  wire signed [12:0] ofs_adj;
  wire signed [12:0] ofs_seg2;
  wire signed [12:0] ofs_seg3;

  stcl_fxmul u_gain_tc (
    .coef(tslot[`STCL_HI_MSB:`STCL_HI_LSB]),
    .val(dt_q),
    .prod(gain_adj)
  );
  stcl_fxmul u_ofs_tc (
    .coef(tslot[`STCL_LO_MSB:0]),
    .val(dt_q),
    .prod(ofs_adj)
  );
  stcl_fxmul u_ofs_seg2 (
    .coef(slot_q[1][`STCL_LO_MSB:0]),
    .val(seg21_q),
    .prod(ofs_seg2)
  );
  stcl_fxmul u_ofs_seg3 (
    .coef(slot_q[2][`STCL_LO_MSB:0]),
    .val(seg32_q),
    .prod(ofs_seg3)
  );

  // Lower gaps contribute their full span correction
  wire signed [14:0] seg2_term = (active_gap_q >= 2'h2) ? {{2{ofs_seg2[12]}}, ofs_seg2} : 15'h0000;
  wire signed [14:0] seg3_term = (active_gap_q == 2'h3) ? {{2{ofs_seg3[12]}}, ofs_seg3} : 15'h0000;
  wire signed [14:0] ofs_acc = {{2{ofs_adj[12]}}, ofs_adj} + seg2_term + seg3_term;

  // Gain code: fine gain plus drift term, times the coarse step
  wire signed [13:0] gain_sum = $signed({4'h0, fine_gain}) + {gain_adj[12], gain_adj};
  wire [3:0] coarse_mult = {1'b0, coarse_gain_sel} + 4'h1;
  wire signed [18:0] gain_prod = gain_sum * $signed({1'b0, coarse_mult});
  wire signed [15:0] dac_gain_d = gain_prod[15:0];

  // Offset centred on mid code, widened by the coarse step
  wire signed [15:0] ofs_ctr = {6'h00, fine_offset} - `STCL_OFS_MID;
  wire signed [15:0] ofs_base = ofs_ctr <<< coarse_offset_sel;
  wire signed [15:0] dac_offset_d = ofs_base + {ofs_acc[14], ofs_acc};

  // Differential input, optionally swapped, clamped at zero
  wire signed [10:0] diff_pn = {1'b0, bridge_in_pos} - {1'b0, bridge_in_neg};
  wire signed [10:0] diff_np = {1'b0, bridge_in_neg} - {1'b0, bridge_in_pos};
  wire signed [10:0] diff_sel = invert_sel ? diff_np : diff_pn;

  // Offset enters before the gain so the gain also scales it
  wire signed [16:0] ofs_sum = $signed({7'h00, raw_q}) + {dac_offset_q[15], dac_offset_q};
  wire signed [32:0] cond_prod = ofs_sum * dac_gain_q;
  wire signed [22:0] cond_scaled = cond_prod[32:`STCL_FRAC_BITS];

  // Linearization gap: highest break point not above the signal
  always @*
  begin
    lgap_d = 2'h0;
    probe_idx = 3'h0;
    for (k = 1; k < 4; k = k + 1)
    begin
      probe_idx = ntg + k[2:0];
      if ((k[2:0] < nlg) && (slot_q[probe_idx][9:0] <= cond_q))
        lgap_d = k[1:0];
    end
  end

  // Linearization slots follow the temperature slots
  wire [2:0] lin_idx = ntg + {1'b0, lgap_d};
  wire [23:0] lslot = slot_q[lin_idx];
  wire [9:0] lin_bp = lslot[9:0];
  wire signed [10:0] lin_diff = {1'b0, cond_q} - {1'b0, lin_bp};
  wire signed [12:0] lin_adj;

  // Unity slope 1024 returns the difference unchanged
  stcl_fxmul u_lin_slope (
    .coef(lslot[`STCL_HI_MSB:`STCL_HI_LSB]),
    .val(lin_diff),
    .prod(lin_adj)
  );

  wire signed [13:0] lin_val = $signed({4'h0, lin_bp}) + {lin_adj[12], lin_adj};

  // Shared coefficient store, written by slot index
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      for (i = 0; i < 5; i = i + 1)
        slot_q[i] <= `STCL_SLOT_RST;
    end
    else if (clk_en && coef_wr_en && (coef_wr_idx < `STCL_NUM_SLOTS))
    begin
      slot_q[coef_wr_idx] <= {coef_wr_hi, coef_wr_lo};
    end
  end

  // Temperature stage updates only on a fresh filtered sample
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      active_gap_q <= 2'h0;
      dt_q <= 11'h000;
      seg21_q <= 11'h000;
      seg32_q <= 11'h000;
    end
    else if (clk_en && temp_valid)
    begin
      active_gap_q <= gap_d;
      dt_q <= dt_d;
      seg21_q <= k2_ext - k1_ext;
      seg32_q <= k3_ext - k2_ext;
    end
  end

  // Converter codes follow the held gap every enabled cycle
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      dac_gain_q <= 16'h0000;
      dac_offset_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      dac_gain_q <= dac_gain_d;
      dac_offset_q <= dac_offset_d;
    end
  end

  // Three-stage signal pipe: input, conditioned, output
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      raw_q <= 10'h000;
      raw_vld_q <= 1'b0;
      cond_q <= 10'h000;
      cond_vld_q <= 1'b0;
      sig_out_q <= 10'h000;
      lin_gap_q <= 2'h0;
      out_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      raw_vld_q <= sig_valid;
      if (sig_valid)
        raw_q <= sat10({{12{diff_sel[10]}}, diff_sel});
      cond_vld_q <= raw_vld_q;
      if (raw_vld_q)
        cond_q <= sat10(cond_scaled);
      out_valid_q <= cond_vld_q;
      if (cond_vld_q)
      begin
        lin_gap_q <= digital_mode ? lgap_d : 2'h0;
        // Analog mode passes the conditioned value untouched
        if (digital_mode)
          sig_out_q <= sat10({{9{lin_val[13]}}, lin_val});
        else
          sig_out_q <= cond_q;
      end
    end
  end
endmodule

/* File: dv/stcl_lin_monitor.sv */
// Checker for the compensation datapath
`timescale 1ns/1ps
module stcl_lin_monitor (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  input wire digital_mode,
  input wire sig_valid,
  input wire temp_valid,
  input wire [9:0] temp_filt,
  input wire [9:0] temp_knee_first,
  input wire [9:0] temp_knee_second,
  input wire [9:0] temp_knee_third,
  input wire [1:0] active_gap_q,
  input wire [9:0] sig_out_q,
  input wire [1:0] lin_gap_q,
  input wire out_valid_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Sample taken with ascending knees; other orders are a programming fault
  wire tk = temp_valid && clk_en && temp_knee_first < temp_knee_second
    && temp_knee_second < temp_knee_third;
  out_latency_a: assert property (sig_valid && clk_en ##1 clk_en[*2] |=> out_valid_q)
    else $error("no output pulse");
  gap_first_a: assert property (tk && temp_filt <= temp_knee_first
    |=> active_gap_q == 2'h0) else $error("gap 0 wrong");
  gap_second_a: assert property (tk && temp_filt > temp_knee_first
    && temp_filt <= temp_knee_second |=> active_gap_q == 2'h1) else $error("gap 1 wrong");
  gap_third_a: assert property (tk && temp_filt > temp_knee_second
    && temp_filt <= temp_knee_third |=> active_gap_q == 2'h2) else $error("gap 2 wrong");
  gap_top_a: assert property (tk && temp_filt > temp_knee_third
    |=> active_gap_q == 2'h3) else $error("gap 3 wrong");
  gap_hold_a: assert property (!(temp_valid && clk_en) |=> $stable(active_gap_q))
    else $error("gap moved");
  out_hold_a: assert property ($changed(sig_out_q) && $past(nrst) |-> out_valid_q)
    else $error("output moved");
  analog_gap_a: assert property (out_valid_q && !digital_mode && !$past(digital_mode)
    && !$past(digital_mode, 2) |-> lin_gap_q == 2'h0) else $error("analog gap");
endmodule
bind stcl_lin_core stcl_lin_monitor mon (.ref_clk, .nrst, .clk_en, .digital_mode, .sig_valid,
  .temp_valid, .temp_filt, .temp_knee_first, .temp_knee_second, .temp_knee_third,
  .active_gap_q, .sig_out_q, .lin_gap_q, .out_valid_q);

/* File: dv/stcl_bridge_model.sv */
// Model of the bridge and temperature converters
`timescale 1ns/1ps
module stcl_bridge_model (
  input wire ref_clk,
  output reg sig_valid = 1'b0,
  output reg [9:0] bridge_in_pos = 10'h155,
  output reg [9:0] bridge_in_neg = 10'h2aa,
  output reg temp_valid = 1'b0,
  output reg [9:0] temp_filt = 10'h155
);
  // One-cycle result; lines invert after so stale use shows
  task sig(input [9:0] p, input [9:0] n);
    @(posedge ref_clk);
    sig_valid <= 1'b1;
    bridge_in_pos <= p;
    bridge_in_neg <= n;
    @(posedge ref_clk);
    sig_valid <= 1'b0;
    bridge_in_pos <= ~p;
    bridge_in_neg <= ~n;
  endtask
  // Filtered temperature sample
  task temp(input [9:0] t);
    @(posedge ref_clk);
    temp_valid <= 1'b1;
    temp_filt <= t;
    @(posedge ref_clk);
    temp_valid <= 1'b0;
    temp_filt <= ~t;
  endtask
endmodule

/* File: dv/stcl_lin_core_test.sv */
// Self-checking bench for the compensation datapath
`timescale 1ns/1ps
module stcl_lin_core_test;
  reg ref_clk = 1'b0, nrst = 1'b0, invert_sel = 1'b0, digital_mode = 1'b0, coef_wr_en = 1'b0;
  reg clk_en = 1'b1;
  reg [9:0] temp_knee_first = 10'h064, temp_knee_second = 10'h0c8;
  reg [9:0] temp_knee_third = 10'h12c, fine_gain = 10'h200, fine_offset = 10'h200;
  reg [2:0] coarse_gain_sel = 3'h1, num_temp_gaps = 3'h4, coef_wr_idx = 3'h0;
  reg [1:0] coarse_offset_sel = 2'h0;
  reg [11:0] coef_wr_hi = 12'h000, coef_wr_lo = 12'h000;
  wire sig_valid, temp_valid, out_valid_q;
  wire [9:0] bridge_in_pos, bridge_in_neg, temp_filt, sig_out_q;
  wire [1:0] active_gap_q, lin_gap_q;
  wire signed [15:0] dac_gain_q, dac_offset_q;
  int n_fail = 0, total_checks = 0, i;
  // Rows: sample, gap, gain code, offset code
  logic [43:0] trow [8] = '{44'h0c804640032, 44'h19004000000, 44'h32104c80064,
    44'h3ea04640096, 44'h4b204c800c8, 44'h4b7040200c9, 44'hfff09a6039b, 44'h00004c80064};
  // Rows: pos, neg, invert and digital flags, output, linear gap
  logic [43:0] srow [7] = '{44'h12c000112c0, 44'h2bc00012581, 44'h0002bc32581,
    44'h3ff00013ff2, 44'h38400013e72, 44'h2bc00002bc0, 44'h0002bc10000};
  stcl_lin_core dut (.ref_clk, .nrst, .clk_en, .invert_sel, .digital_mode, .sig_valid,
    .bridge_in_pos, .bridge_in_neg, .temp_valid, .temp_filt, .temp_knee_first,
    .temp_knee_second, .temp_knee_third, .coarse_gain_sel, .fine_gain, .coarse_offset_sel,
    .fine_offset, .num_temp_gaps, .coef_wr_en, .coef_wr_idx, .coef_wr_hi, .coef_wr_lo,
    .active_gap_q, .dac_gain_q, .dac_offset_q, .sig_out_q, .lin_gap_q, .out_valid_q);
  stcl_bridge_model m (.ref_clk, .sig_valid, .bridge_in_pos, .bridge_in_neg, .temp_valid,
    .temp_filt);
  // Clock
  initial
    forever #5 ref_clk = ~ref_clk;
  task chk(input [15:0] got, input [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Slot write; strobe drops for a cycle between writes
  task wr(input [2:0] x, input [11:0] h, input [11:0] l);
    @(posedge ref_clk);
    coef_wr_en <= 1'b1;
    coef_wr_idx <= x;
    coef_wr_hi <= h;
    coef_wr_lo <= l;
    @(posedge ref_clk);
    coef_wr_en <= 1'b0;
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence; no checksum or temperature amplifier port here
  initial
  begin
    // Reset held for three edges, outputs still cleared after release
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    chk(dac_gain_q, 16'h0000);
    chk(16'(sig_out_q), 16'h0000);
    for (i = 0; i < 4; i++)
      wr(3'(i), 12'h400, 12'h400);
    for (i = 0; i < 8; i++)
    begin
      m.temp(trow[i][43:34]);
      repeat (3) @(posedge ref_clk);
      #1;
      chk(16'(active_gap_q), 16'(trow[i][33:32]));
      chk(dac_gain_q, trow[i][31:16]);
      chk(dac_offset_q, trow[i][15:0]);
    end
    // Two temperature gaps: unused knees parked at the top code
    @(posedge ref_clk);
    temp_knee_second <= 10'h3ff;
    temp_knee_third <= 10'h3ff;
    m.temp(10'h064);
    num_temp_gaps <= 3'h2;
    wr(3'h2, 12'h400, 12'h000);
    wr(3'h3, 12'h200, 12'h1f4);
    wr(3'h4, 12'h7ff, 12'h320);
    wr(3'h5, 12'h000, 12'h000);
    for (i = 0; i < 7; i++)
    begin
      @(posedge ref_clk);
      invert_sel <= srow[i][17];
      digital_mode <= srow[i][16];
      m.sig(srow[i][41:32], srow[i][29:20]);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(16'(out_valid_q), 16'h0001);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(16'(sig_out_q), 16'(srow[i][13:4]));
      chk(16'(lin_gap_q), 16'(srow[i][1:0]));
      chk(16'(out_valid_q), 16'h0000);
    end
    @(posedge ref_clk);
    digital_mode <= 1'b0;
    coarse_gain_sel <= 3'h3;
    @(posedge ref_clk);
    fine_offset <= 10'h264;
    coarse_offset_sel <= 2'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(dac_gain_q, 16'h0800);
    chk(dac_offset_q, 16'h00c8);
    m.sig(10'h064, 10'h000);
    repeat (4) @(posedge ref_clk);
    #1;
    chk(16'(sig_out_q), 16'h0258);
    // Enable low: a fresh sample must move neither the gap nor the offset code
    @(posedge ref_clk);
    clk_en <= 1'b0;
    m.temp(10'h3ff);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'(active_gap_q), 16'h0000);
    chk(dac_offset_q, 16'h00c8);
    // Mid-run reset clears the gap and the converter codes
    @(posedge ref_clk);
    clk_en <= 1'b1;
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    chk(16'(active_gap_q), 16'h0000);
    chk(dac_gain_q, 16'h0000);
    tally_and_finish;
  end
  // Whole run is under two microseconds; this cuts a hang
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
endmodule
